// *** hdl/ilo_pkg.sv ***
// Package with constants and carrier types for the indexed literal offset address decoder.
package ilo_pkg;

  // ---------------------------------------------------------------------------
  // Widths and address map
  // ---------------------------------------------------------------------------
  localparam int DATA_ADDR_W = 12;
  localparam int FILE_W = 8;
  localparam int BANK_W = 4;
  localparam int BUS_ADDR_W = 8;
  localparam int BUS_DATA_W = 32;

  localparam logic [BUS_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [BUS_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic CTRL_EXT_RESET = 1'b0;
  localparam int STATUS_INDEXED_BIT = 12;

  // Operands at or below this value are offsets when indexing is active.
  localparam logic [FILE_W-1:0] OFFSET_LIMIT = 8'h5f;
  // Upper part of the access bank (operands above 5Fh, 160 bytes) lies in the top bank.
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic mem_op;
    logic [FILE_W-1:0] file;
    logic access_sel;
    logic dest_sel;
    logic bit_op;
    logic [2:0] bit_num;
  } decode_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_ADDR_W-1:0] addr;
    logic indexed;
    logic dest_file;
    logic bit_op;
    logic [7:0] bit_mask;
  } decode_res_t;

  // True when an operand falls in the offset window.
  function automatic logic in_offset_window(input logic [FILE_W-1:0] file);
    return file <= OFFSET_LIMIT;
  endfunction

  // One-hot mask for a bit number.
  function automatic logic [7:0] bit_to_mask(input logic [2:0] num);
    return 8'h01 << num;
  endfunction

endpackage

// *** hdl/ilo_addr_calc.sv ***
// Combinational effective data address calculation for one operand.
`timescale 1ns/1ps
module ilo_addr_calc
  import ilo_pkg::*;
(
  input wire logic ext_en_i,
  input wire logic [ilo_pkg::FILE_W-1:0] file_i,
  input wire logic access_sel_i,
  input wire logic [ilo_pkg::DATA_ADDR_W-1:0] stack_frame_pointer_i,
  input wire logic [ilo_pkg::BANK_W-1:0] bank_select_register_i,
  output logic [ilo_pkg::DATA_ADDR_W-1:0] addr_o,
  output logic indexed_o
);

  always_comb begin
    indexed_o = ext_en_i && !access_sel_i && in_offset_window(file_i);
    if (access_sel_i) begin
      addr_o = {bank_select_register_i, file_i};
    end else if (indexed_o) begin
      // The sum wraps inside data space, as the pointer itself does.
      addr_o = DATA_ADDR_W'(stack_frame_pointer_i + {4'h0, file_i});
    end else if (in_offset_window(file_i)) begin
      addr_o = {ACCESS_LOW_BANK, file_i};
    end else begin
      addr_o = {ACCESS_HIGH_BANK, file_i};
    end
  end

endmodule // ilo_addr_calc

// *** hdl/ilo_decoder.sv ***
// Operand address decoder for the indexed literal offset addressing mode.
//
// Function
// - Extension enable also turns on indexed addressing.
// - Disabled: access bank or banked literal address.
// - Enabled, access, operand <=5Fh: pointer plus offset.
// - Operands above 5Fh keep access bank meaning.
// - All byte and bit operand instructions remap.
// - Pointer zero maps like ordinary access bank.
// - Destination select keeps its standard role.
// - Indexed bit set targets pointer plus offset, one cycle.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module ilo_decoder
  import ilo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ilo_pkg::BUS_ADDR_W-1:0] bus_addr_i,
  input wire logic [ilo_pkg::BUS_DATA_W-1:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [ilo_pkg::BUS_DATA_W-1:0] bus_rdata_o,
  input wire ilo_pkg::decode_req_t req_i,
  input wire logic [ilo_pkg::DATA_ADDR_W-1:0] stack_frame_pointer_i,
  input wire logic [ilo_pkg::BANK_W-1:0] bank_select_register_i,
  output ilo_pkg::decode_res_t res_o,
  output logic ext_en_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic ext_en;
    logic [BUS_DATA_W-1:0] rdata;
    decode_res_t res;
  } state_t;

  state_t state;
  state_t next_state;
  logic [DATA_ADDR_W-1:0] calc_addr;
  logic calc_indexed;

  // ---------------------------------------------------------------------------
  // Address arithmetic
  // ---------------------------------------------------------------------------
  // The adder is purely combinational so the operand read cycle already
  // carries the final address; indexed forms cost no extra cycle.
  ilo_addr_calc u_addr_calc (
    .ext_en_i(state.ext_en),
    .file_i(req_i.file),
    .access_sel_i(req_i.access_sel),
    .stack_frame_pointer_i(stack_frame_pointer_i),
    .bank_select_register_i(bank_select_register_i),
    .addr_o(calc_addr),
    .indexed_o(calc_indexed)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    // Software owns the enable; it powers up clear so legacy code runs.
    if (bus_wr_i && bus_addr_i == CTRL_OFFSET) begin
      next_state.ext_en = bus_wdata_i[CTRL_EXT_BIT];
    end
    next_state.rdata = '0;
    if (bus_rd_i) begin
      case (bus_addr_i)
        CTRL_OFFSET: begin
          next_state.rdata[CTRL_EXT_BIT] = state.ext_en;
        end
        STATUS_OFFSET: begin
          next_state.rdata[DATA_ADDR_W-1:0] = state.res.addr;
          next_state.rdata[STATUS_INDEXED_BIT] = state.res.indexed;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end
    // Every operand carrying the access select bit goes through the same path.
    next_state.res.valid = req_i.valid && req_i.mem_op;
    if (req_i.valid && req_i.mem_op) begin
      next_state.res.addr = calc_addr;
      next_state.res.indexed = calc_indexed;
      next_state.res.dest_file = req_i.dest_sel;
      next_state.res.bit_op = req_i.bit_op;
      next_state.res.bit_mask = req_i.bit_op ? bit_to_mask(req_i.bit_num) : 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '0;
      state.ext_en <= CTRL_EXT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign bus_rdata_o = state.rdata;
  assign res_o = state.res;
  assign ext_en_o = state.ext_en;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic req_mem;
  assign req_mem = req_i.valid && req_i.mem_op;

  ext_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && state.ext_en && !req_i.access_sel && req_i.file <= OFFSET_LIMIT)
      |=> res_o.indexed)
    else $error("offset operand not indexed with extension on");

  literal_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && !state.ext_en) |=> !res_o.indexed)
    else $error("indexed decode while extension off");

  banked_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && req_i.access_sel)
      |=> res_o.addr == {$past(bank_select_register_i), $past(req_i.file)})
    else $error("banked address wrong");

  high_access_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && !req_i.access_sel && req_i.file > OFFSET_LIMIT)
      |=> (res_o.addr == {4'hf, $past(req_i.file)}) && !res_o.indexed)
    else $error("high access operand remapped");

  index_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && state.ext_en && !req_i.access_sel && req_i.file <= OFFSET_LIMIT)
      |=> res_o.addr == DATA_ADDR_W'($past(stack_frame_pointer_i) + $past(req_i.file)))
    else $error("indexed address is not pointer plus offset");

  zero_pointer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && !req_i.access_sel && req_i.file <= OFFSET_LIMIT
      && stack_frame_pointer_i == 12'h000)
      |=> res_o.addr == {4'h0, $past(req_i.file)})
    else $error("zero pointer does not match access bank");

  dest_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_mem |=> res_o.dest_file == $past(req_i.dest_sel))
    else $error("destination select altered");

  bit_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_mem && req_i.bit_op)
      |=> res_o.bit_op && res_o.bit_mask == (8'h01 << $past(req_i.bit_num)))
    else $error("bit set mask wrong");

  one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_mem |=> res_o.valid ##1 (res_o.valid == $past(req_mem)))
    else $error("decode result not in one cycle");

  no_op_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_mem |=> !res_o.valid)
    else $error("result without a memory operand request");

endmodule // ilo_decoder

// *** test/ilo_decoder_bench.sv ***
// Self-checking testbench for the indexed literal offset address decoder.
`timescale 1ns/1ps
module ilo_decoder_bench;
  import ilo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [BUS_ADDR_W-1:0] bus_addr_i = 8'h00;
  logic [BUS_DATA_W-1:0] bus_wdata_i = 32'h0;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  logic [BUS_DATA_W-1:0] bus_rdata_o;
  decode_req_t req_i = '0;
  logic [DATA_ADDR_W-1:0] stack_frame_pointer_i = 12'h000;
  logic [BANK_W-1:0] bank_select_register_i = 4'h0;
  decode_res_t res_o;
  logic ext_en_o;
  int num_errors = 0;
  int n_checks = 0;
  // Extension state as the bench last wrote it, kept apart from the design's output.
  logic ext_set = 1'b0;
  logic [7:0] files [6] = '{8'h00, 8'h0a, 8'h2c, 8'h5f, 8'h60, 8'hff};
  logic [11:0] ptrs [3] = '{12'ha00, 12'h000, 12'hfff};

  ilo_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .req_i(req_i), .stack_frame_pointer_i(stack_frame_pointer_i),
    .bank_select_register_i(bank_select_register_i), .res_o(res_o), .ext_en_o(ext_en_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------------------
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_res(input decode_res_t got, input decode_res_t exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_wr_i <= 1'b1;
    if (a == CTRL_OFFSET) ext_set = d[CTRL_EXT_BIT];
    @(posedge clk_i);
    bus_wr_i <= 1'b0;
    // Let the register settle so callers may look at it right away.
    #1;
  endtask

  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'b1;
    @(posedge clk_i);
    bus_rd_i <= 1'b0;
    #1 check32(bus_rdata_o, exp);
  endtask

  // The expected address is worked out here independently of the design.
  task automatic decode(input logic [7:0] f, input logic a, input logic [11:0] p,
                        input logic mem, output decode_res_t exp);
    logic ext;
    logic low;
    ext = ext_set;
    low = (f <= 8'h5f);
    exp.valid = 1'b1;
    exp.indexed = ext & ~a & low;
    if (a) exp.addr = {p[3:0] ^ 4'h5, f};
    else if (exp.indexed) exp.addr = p + {4'h0, f};
    else exp.addr = {low ? 4'h0 : 4'hf, f};
    exp.dest_file = f[0];
    exp.bit_op = f[1];
    exp.bit_mask = f[1] ? (8'h01 << f[4:2]) : 8'h00;
    @(posedge clk_i);
    req_i <= '{1'b1, mem, f, a, f[0], f[1], f[4:2]};
    stack_frame_pointer_i <= p;
    bank_select_register_i <= p[3:0] ^ 4'h5;
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    #1;
    if (mem) check_res(res_o, exp);
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    decode_res_t e;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_read(CTRL_OFFSET, 32'h0);
    check32({31'h0, ext_en_o}, 32'h0);
    bus_read(8'h20, 32'h0);
    for (int x = 0; x < 2; x++) begin
      if (x == 1) bus_write(CTRL_OFFSET, 32'h3);
      check32({31'h0, ext_en_o}, x);
      foreach (ptrs[i]) foreach (files[j]) for (int a = 0; a < 2; a++) begin
        decode(files[j], a[0], ptrs[i], 1'b1, e);
        bus_read(STATUS_OFFSET, {19'h0, e.indexed, e.addr});
      end
    end
    bus_read(CTRL_OFFSET, 32'h1);
    bus_write(STATUS_OFFSET, 32'hffff);
    decode(8'h33, 1'b0, 12'h100, 1'b0, e);
    check32({31'h0, res_o.valid}, 32'h0);
    // Last accepted decode was banked: bank 4'hf ^ 4'h5, operand 8'hff, not indexed.
    bus_read(STATUS_OFFSET, {19'h0, 1'b0, 4'ha, 8'hff});
    bus_write(CTRL_OFFSET, 32'h0);
    decode(8'h2c, 1'b0, 12'ha00, 1'b1, e);
    give_verdict();
  end
endmodule // ilo_decoder_bench
